// File: verilog/asx_core.sv
// asx_core: execution datapath for subtract, xor, swap, direction load and sleep,
// with accumulator, 128-byte file register space and watchdog, over AXI4-Lite.
// assumes: single 20 MHz clock, bus master keeps AXI4-Lite valid/ready rules.
// Contract
// - literal minus accumulator into accumulator
// - subtracts update carry; set when acc + borrow <= operand, borrow 0 except in borrow subtract
// - register minus accumulator to chosen destination
// - borrow subtract uses inverted carry as borrow
// - borrow subtract: dest 0 acc, 1 register
// - nibble exchange swaps halves, flags untouched
// - nibble exchange: dest set register, clear acc
// - direction load: 5 A, 6 B, 7 C
// - literal xor into accumulator, zero only
// - register xor updates only zero flag
// - register xor: dest 0 acc, 1 register
// - sleep clears watchdog count and prescaler
// - sleep clears power-down, sets expired flag
// - sleep halts execution, stops oscillator until wake
`include "asx_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module asx_core #(
  parameter int unsigned PRESCALE = 128
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [`ASX_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`ASX_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic wake_req,
  output logic osc_enable,
  output logic wdt_timeout,
  output logic [7:0] port_a_direction,
  output logic [7:0] port_b_direction,
  output logic [7:0] port_c_direction,
  output asx_pkg::asx_status_t status_flags
);
  import asx_pkg::*;

  if (PRESCALE < 2 || PRESCALE > 65536) begin : g_bad_prescale
    $error("PRESCALE must lie in 2..65536");
  end

  logic [7:0] acc_ff;
  asx_status_t st_ff;
  asx_instr_t instr_ff;
  asx_pwr_t pwr_ff;
  logic [7:0] dir_a_ff, dir_b_ff, dir_c_ff;
  logic [7:0] wdt_ff;
  logic [15:0] pre_ff;
  logic tmo_ff;
  logic [7:0] file_mem [0:127];

  logic aw_hold_ff, w_hold_ff, bvalid_ff, rvalid_ff;
  logic [`ASX_AW-1:0] awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff;

  // write channel: address and data are held independently, then applied together
  assign s_axi_awready = !aw_hold_ff;
  assign s_axi_wready = !w_hold_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  wire wr_fire = aw_hold_ff & w_hold_ff & !bvalid_ff;
  wire [`ASX_AW-1:0] wa = awaddr_ff;
  wire lane0 = wstrb_ff[0];
  wire hit_acc = wa == `ASX_OFF_ACC;
  wire hit_status = wa == `ASX_OFF_STATUS;
  wire hit_instr = wa == `ASX_OFF_INSTR;
  wire hit_wfile = wa[11:9] == `ASX_FILE_TAG;
  wire wr_acc = wr_fire & hit_acc & lane0;
  wire wr_status = wr_fire & hit_status & lane0;
  wire wr_file = wr_fire & hit_wfile & lane0;

  // instruction decode; the word spans lanes 0 and 1, so both must be strobed
  wire asx_instr_t instr_new = asx_instr_t'(wdata_ff[`ASX_OP_MSB:0]);
  wire [3:0] op = instr_new.op;
  wire [7:0] lit = instr_new.arg;
  wire [6:0] fadr = instr_new.arg[6:0];
  wire dest = instr_new.arg[`ASX_DEST_BIT];
  wire is_lsub = op == `ASX_OP_LIT_SUB;
  wire is_rsub = op == `ASX_OP_REG_SUB;
  wire is_rsubb = op == `ASX_OP_REG_SUBB;
  wire is_swap = op == `ASX_OP_NIB_SWAP;
  wire is_dir = op == `ASX_OP_DIR_LOAD;
  wire is_lxor = op == `ASX_OP_LIT_XOR;
  wire is_rxor = op == `ASX_OP_REG_XOR;
  wire is_sleep = op == `ASX_OP_SLEEP;
  wire is_sub = is_lsub | is_rsub | is_rsubb;
  wire is_xor = is_lxor | is_rxor;
  wire is_lit = is_lsub | is_lxor;
  wire dir_ok = fadr == `ASX_SEL_DIR_A || fadr == `ASX_SEL_DIR_B || fadr == `ASX_SEL_DIR_C;
  wire op_ok = (op == `ASX_OP_NOP) | is_sub | is_swap | (is_dir & dir_ok) | is_xor | is_sleep;
  wire running = pwr_ff == PWR_RUN;
  // a sleeping core refuses instruction writes rather than queueing them
  wire instr_try = wr_fire & hit_instr & (&wstrb_ff[1:0]);
  wire exec_go = instr_try & op_ok & running;

  // operands and results
  wire [7:0] fval = file_mem[fadr];
  wire [7:0] opnd = is_lit ? lit : fval;
  wire cin = is_rsubb ? st_ff.carry : 1'b1;
  // operand + ~acc + cin: carry out means acc + !cin did not exceed operand
  wire [8:0] sum9 = {1'b0, opnd} + {1'b0, ~acc_ff} + {8'h00, cin};
  wire [4:0] nib5 = {1'b0, opnd[3:0]} + {1'b0, ~acc_ff[3:0]} + {4'h0, cin};
  wire [7:0] xr = acc_ff ^ opnd;
  wire [7:0] sw = {fval[3:0], fval[7:4]};
  wire [7:0] result = is_sub ? sum9[7:0] : (is_xor ? xr : sw);
  wire reg_form = is_rsub | is_rsubb | is_rxor | is_swap;
  wire to_acc = exec_go & (is_lit | (reg_form & !dest));
  wire to_file = exec_go & reg_form & dest;
  wire sleep_go = exec_go & is_sleep;

  // watchdog: prescaler gives a one-cycle tick, count overflows wake the core
  wire pre_tick = pre_ff == 16'(PRESCALE - 1);
  wire wdt_ovf = pre_tick & (wdt_ff == 8'hFF) & !sleep_go;

  // read decode
  wire [`ASX_AW-1:0] ra = s_axi_araddr;
  wire hit_rfile = ra[11:9] == `ASX_FILE_TAG;
  wire rd_ok = hit_rfile || ra == `ASX_OFF_ACC || ra == `ASX_OFF_STATUS ||
               ra == `ASX_OFF_INSTR || ra == `ASX_OFF_DIR_A || ra == `ASX_OFF_DIR_B ||
               ra == `ASX_OFF_DIR_C || ra == `ASX_OFF_WDT;
  wire [31:0] rd_mux =
    hit_rfile ? {24'h000000, file_mem[ra[8:2]]} :
    ra == `ASX_OFF_ACC ? {24'h000000, acc_ff} :
    ra == `ASX_OFF_STATUS ? {26'h0000000, !running, st_ff} :
    ra == `ASX_OFF_INSTR ? {20'h00000, instr_ff} :
    ra == `ASX_OFF_DIR_A ? {24'h000000, dir_a_ff} :
    ra == `ASX_OFF_DIR_B ? {24'h000000, dir_b_ff} :
    ra == `ASX_OFF_DIR_C ? {24'h000000, dir_c_ff} :
    ra == `ASX_OFF_WDT ? {24'h000000, wdt_ff} : 32'h00000000;
  wire wr_map_ok = hit_acc | hit_status | hit_wfile | (hit_instr & (op_ok & running)) |
                   wa == `ASX_OFF_DIR_A | wa == `ASX_OFF_DIR_B | wa == `ASX_OFF_DIR_C |
                   wa == `ASX_OFF_WDT;

  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign osc_enable = running;
  assign wdt_timeout = tmo_ff;
  assign port_a_direction = dir_a_ff;
  assign port_b_direction = dir_b_ff;
  assign port_c_direction = dir_c_ff;
  assign status_flags = st_ff;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_hold_ff <= 1'b0;
      awaddr_ff <= '0;
      w_hold_ff <= 1'b0;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `ASX_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_hold_ff) begin
        aw_hold_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_hold_ff <= 1'b0;
      end
      if (s_axi_wvalid && !w_hold_ff) begin
        w_hold_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_hold_ff <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_map_ok ? `ASX_RESP_OKAY : `ASX_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= `ASX_RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_ff) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_mux;
      rresp_ff <= rd_ok ? `ASX_RESP_OKAY : `ASX_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // file registers carry no reset, as in a real data memory
  always_ff @(posedge sys_clk) begin
    if (wr_file) begin
      file_mem[wa[8:2]] <= wdata_ff[7:0];
    end else if (to_file) begin
      file_mem[fadr] <= result;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_ff <= `ASX_RST_ACC;
      instr_ff <= '0;
    end else if (wr_acc) begin
      acc_ff <= wdata_ff[7:0];
    end else if (exec_go) begin
      instr_ff <= instr_new;
      if (to_acc) begin
        acc_ff <= result;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= 5'b11000;
    end else begin
      if (wr_status) begin
        st_ff.carry <= wdata_ff[0];
        st_ff.nibble_carry_flag <= wdata_ff[1];
        st_ff.result_null_flag <= wdata_ff[2];
      end else if (exec_go && is_sub) begin
        st_ff.carry <= sum9[8];
        st_ff.nibble_carry_flag <= nib5[4];
        st_ff.result_null_flag <= result == 8'h00;
      end else if (exec_go && is_xor) begin
        st_ff.result_null_flag <= result == 8'h00;
      end
      if (sleep_go) begin
        st_ff.power_down_flag <= 1'b0;
        st_ff.watchdog_expired_flag <= 1'b1;
      end else if (wdt_ovf) begin
        st_ff.watchdog_expired_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dir_a_ff <= `ASX_RST_DIR;
      dir_b_ff <= `ASX_RST_DIR;
      dir_c_ff <= `ASX_RST_DIR;
    end else if (exec_go && is_dir) begin
      if (fadr == `ASX_SEL_DIR_A) dir_a_ff <= acc_ff;
      if (fadr == `ASX_SEL_DIR_B) dir_b_ff <= acc_ff;
      if (fadr == `ASX_SEL_DIR_C) dir_c_ff <= acc_ff;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_ff <= 16'h0000;
      wdt_ff <= 8'h00;
      tmo_ff <= 1'b0;
    end else begin
      tmo_ff <= wdt_ovf;
      if (sleep_go) begin
        pre_ff <= 16'h0000;
        wdt_ff <= 8'h00;
      end else if (pre_tick) begin
        pre_ff <= 16'h0000;
        wdt_ff <= wdt_ff + 8'h01;
      end else begin
        pre_ff <= pre_ff + 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pwr_ff <= PWR_RUN;
    end else begin
      unique case (pwr_ff)
        PWR_RUN: if (sleep_go) pwr_ff <= PWR_SLEEP;
        PWR_SLEEP: if (wake_req || wdt_ovf) pwr_ff <= PWR_RUN;
      endcase
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  chk_lit_sub_value: assert property (exec_go && is_lsub |=>
    acc_ff == 8'($past(lit) - $past(acc_ff))) else $error("literal subtract wrong");
  chk_sub_carry_rule: assert property (exec_go && (is_lsub || is_rsub) |=>
    st_ff.carry == ($past(acc_ff) <= $past(opnd))) else $error("subtract carry wrong");
  chk_nibble_zero: assert property (exec_go && (is_lsub || is_rsub) |=>
    st_ff.nibble_carry_flag == ($past(acc_ff[3:0]) <= $past(opnd[3:0])) &&
    st_ff.result_null_flag == ($past(result) == 8'h00)) else $error("nibble or zero wrong");
  chk_reg_sub_acc: assert property (exec_go && is_rsub && !dest |=>
    acc_ff == 8'($past(fval) - $past(acc_ff))) else $error("register subtract wrong");
  chk_borrow_value: assert property (exec_go && is_rsubb && !dest |=>
    acc_ff == 8'($past(fval) - $past(acc_ff) - 8'(!$past(st_ff.carry))))
    else $error("borrow subtract wrong");
  chk_borrow_dest: assert property (exec_go && is_rsubb && dest |=>
    file_mem[$past(fadr)] == $past(result) && $stable(acc_ff)) else $error("borrow dest wrong");
  chk_swap_flags: assert property (exec_go && is_swap |=> $stable(st_ff))
    else $error("swap changed flags");
  chk_swap_dest: assert property (exec_go && is_swap |=>
    ($past(dest) ? file_mem[$past(fadr)] : acc_ff) == {$past(fval[3:0]), $past(fval[7:4])})
    else $error("swap result misplaced");
  chk_dir_load_b: assert property (exec_go && is_dir && fadr == `ASX_SEL_DIR_B |=>
    dir_b_ff == $past(acc_ff) && $stable(dir_a_ff) && $stable(st_ff)) else $error("dir load wrong");
  chk_lit_xor_flags: assert property (exec_go && is_lxor |=>
    acc_ff == ($past(acc_ff) ^ $past(lit)) && $stable(st_ff.carry) &&
    $stable(st_ff.nibble_carry_flag)) else $error("literal xor wrong");
  chk_reg_xor_dest: assert property (exec_go && is_rxor && dest |=>
    file_mem[$past(fadr)] == ($past(acc_ff) ^ $past(fval)) && $stable(acc_ff) &&
    $stable(st_ff.carry)) else $error("register xor wrong");
  chk_sleep_watchdog: assert property (sleep_go |=> wdt_ff == 8'h00 && pre_ff == 16'h0000)
    else $error("sleep left watchdog running");
  chk_sleep_flags: assert property (sleep_go |=>
    !st_ff.power_down_flag && st_ff.watchdog_expired_flag) else $error("sleep flags wrong");
  chk_sleep_halt: assert property (sleep_go ##1 !wake_req [*2] |->
    !osc_enable && $stable(acc_ff)) else $error("core ran while asleep");

endmodule : asx_core
`default_nettype wire

// File: verilog/asx_cfg.svh
// asx_cfg.svh: offsets, field positions, opcodes and reset values
// for the subtract / xor / swap execution datapath.
// assumes: included by asx_pkg users; byte addresses on a 12-bit AXI4-Lite bus.
`ifndef ASX_CFG_SVH
`define ASX_CFG_SVH

`define ASX_AW 12
// register byte offsets
`define ASX_OFF_ACC 12'h000
`define ASX_OFF_STATUS 12'h004
`define ASX_OFF_INSTR 12'h008
`define ASX_OFF_DIR_A 12'h00C
`define ASX_OFF_DIR_B 12'h010
`define ASX_OFF_DIR_C 12'h014
`define ASX_OFF_WDT 12'h018
// file register window: 128 words from 0x200, index in address bits 8:2
`define ASX_FILE_TAG 3'h1

// instruction word fields
`define ASX_OP_MSB 11
`define ASX_OP_LSB 8
`define ASX_DEST_BIT 7

// opcodes
`define ASX_OP_NOP 4'h0
`define ASX_OP_LIT_SUB 4'h1
`define ASX_OP_REG_SUB 4'h2
`define ASX_OP_REG_SUBB 4'h3
`define ASX_OP_NIB_SWAP 4'h4
`define ASX_OP_DIR_LOAD 4'h5
`define ASX_OP_LIT_XOR 4'h6
`define ASX_OP_REG_XOR 4'h7
`define ASX_OP_SLEEP 4'h8

// direction register selectors
`define ASX_SEL_DIR_A 7'h05
`define ASX_SEL_DIR_B 7'h06
`define ASX_SEL_DIR_C 7'h07

// reset values
`define ASX_RST_DIR 8'hFF
`define ASX_RST_ACC 8'h00

// bus responses
`define ASX_RESP_OKAY 2'h0
`define ASX_RESP_SLVERR 2'h2

`endif

// File: verilog/asx_pkg.sv
// asx_pkg: types shared by the datapath and its bench.
// assumes: asx_cfg.svh supplies the numeric constants.
package asx_pkg;
  // carry is bit 0, then nibble carry, zero, power-down, expired
  typedef struct packed {
    logic watchdog_expired_flag;
    logic power_down_flag;
    logic result_null_flag;
    logic nibble_carry_flag;
    logic carry;
  } asx_status_t;

  typedef struct packed {
    logic [3:0] op;
    logic [7:0] arg;
  } asx_instr_t;

  typedef enum logic {PWR_RUN, PWR_SLEEP} asx_pwr_t;
endpackage : asx_pkg

// File: testbench/asx_core_tb.sv
// bench for asx_core: random subtract/xor/swap runs against a bench-side model, direction
// loads, refused requests and both ways out of sleep.
// assumes: asx_cfg.svh on the include path, asx_pkg compiled before this file.
`include "asx_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module alu_subtract_xor_swap_ops_tb_top;
  import asx_pkg::*;
  // small prescale keeps the watchdog overflow run short
  localparam int PS = 64;
  logic sys_clk = 1'h0;
  logic arst_n = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, wake_req = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic osc_enable, wdt_timeout;
  logic [7:0] port_a_direction, port_b_direction, port_c_direction;
  asx_status_t status_flags;
  int fail_count = 0;
  int comparisons = 0;
  int n;
  logic [1:0] wq[$];
  logic [33:0] rq[$];
  logic [31:0] lf = 32'hAA45;
  logic [7:0] acc_m = 8'h00;
  logic [7:0] fr [128];
  logic [7:0] dir_m [3] = '{8'hFF, 8'hFF, 8'hFF};
  logic c_m = 1'h0, dc_m = 1'h0, z_m = 1'h0, pd_m = 1'h1, to_m = 1'h1, sl_m = 1'h0;
  logic [3:0] ops [6] = '{`ASX_OP_LIT_SUB, `ASX_OP_REG_SUB, `ASX_OP_REG_SUBB,
                          `ASX_OP_NIB_SWAP, `ASX_OP_LIT_XOR, `ASX_OP_REG_XOR};

  always #25 sys_clk = ~sys_clk;

  asx_core #(.PRESCALE(PS)) dut_u (
    .sys_clk(sys_clk), .arst_n(arst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .wake_req(wake_req),
    .osc_enable(osc_enable), .wdt_timeout(wdt_timeout), .port_a_direction(port_a_direction),
    .port_b_direction(port_b_direction), .port_c_direction(port_c_direction),
    .status_flags(status_flags)
  );

  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  function automatic logic [31:0] nx(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : nx

  function automatic logic [33:0] st_exp();
    return {28'h0, sl_m, to_m, pd_m, z_m, dc_m, c_m};
  endfunction : st_exp

  // aw and w offered together, each dropped when taken; bready held until bvalid
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic awd;
    logic wd;
    int k;
    awd = 1'h0;
    wd = 1'h0;
    k = 0;
    wq.push_back(er);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (k < 50) begin
      @(posedge sys_clk);
      k++;
      if (!awd && s_axi_awready === 1'h1) begin
        awd = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (!wd && s_axi_wready === 1'h1) begin
        wd = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
      if (s_axi_bvalid === 1'h1) break;
    end
    s_axi_bready <= 1'h0;
    if (k >= 50) fail_count++;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    logic ad;
    int k;
    ad = 1'h0;
    k = 0;
    rq.push_back(e);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (k < 50) begin
      @(posedge sys_clk);
      k++;
      if (!ad && s_axi_arready === 1'h1) begin
        ad = 1'h1;
        s_axi_arvalid <= 1'h0;
      end
      if (s_axi_rvalid === 1'h1) break;
    end
    s_axi_rready <= 1'h0;
    if (k >= 50) fail_count++;
  endtask : rd

  // model first, then execute and read back accumulator, status and the file register
  task automatic exec(input logic [3:0] op, input logic [7:0] arg);
    logic [7:0] o;
    logic [7:0] res;
    logic [8:0] s9;
    logic [4:0] s5;
    logic cin;
    o = (op == `ASX_OP_LIT_SUB || op == `ASX_OP_LIT_XOR) ? arg : fr[arg[6:0]];
    cin = (op == `ASX_OP_REG_SUBB) ? c_m : 1'h1;
    s9 = {1'h0, o} + {1'h0, ~acc_m} + {8'h0, cin};
    s5 = {1'h0, o[3:0]} + {1'h0, ~acc_m[3:0]} + {4'h0, cin};
    res = (op == `ASX_OP_NIB_SWAP) ? {o[3:0], o[7:4]} :
          (op >= `ASX_OP_LIT_XOR) ? (acc_m ^ o) : s9[7:0];
    if (op <= `ASX_OP_REG_SUBB) begin
      c_m = s9[8];
      dc_m = s5[4];
    end
    if (op != `ASX_OP_NIB_SWAP) z_m = (res == 8'h00);
    if (op == `ASX_OP_LIT_SUB || op == `ASX_OP_LIT_XOR || !arg[7]) acc_m = res;
    else fr[arg[6:0]] = res;
    wr(`ASX_OFF_INSTR, {20'h0, op, arg}, 4'hF, `ASX_RESP_OKAY);
    rd(`ASX_OFF_ACC, {26'h0, acc_m});
    rd(`ASX_OFF_STATUS, st_exp());
    // the status pins must agree with the model as well as the bus view
    chk({29'h0, status_flags}, {29'h0, to_m, pd_m, z_m, dc_m, c_m});
    rd(12'h200 | {3'h0, arg[6:0], 2'h0}, {26'h0, fr[arg[6:0]]});
  endtask : exec

  always @(posedge sys_clk) begin
    if (s_axi_bvalid === 1'h1 && s_axi_bready === 1'h1 && wq.size() > 0)
      chk({32'h0, s_axi_bresp}, {32'h0, wq.pop_front()});
    if (s_axi_rvalid === 1'h1 && s_axi_rready === 1'h1 && rq.size() > 0)
      chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
  end

  initial begin
    repeat (60000) @(posedge sys_clk);
    fail_count++;
    end_of_test();
  end

  initial begin
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'h1;
    @(posedge sys_clk);
    chk({10'h0, port_c_direction, port_b_direction, port_a_direction}, {10'h0, 24'hFFFFFF});
    rd(`ASX_OFF_STATUS, st_exp());
    for (int i = 0; i < 128; i++) begin
      lf = nx(lf);
      fr[i] = lf[7:0];
      wr(12'h200 | {3'h0, 7'(i), 2'h0}, {24'h0, lf[7:0]}, 4'hF, `ASX_RESP_OKAY);
    end
    for (int i = 0; i < 48; i++) begin
      lf = nx(lf);
      acc_m = lf[16] ? fr[lf[6:0]] : lf[15:8];
      {z_m, dc_m, c_m} = lf[19:17];
      wr(`ASX_OFF_ACC, {24'h0, acc_m}, 4'hF, `ASX_RESP_OKAY);
      wr(`ASX_OFF_STATUS, {29'h0, z_m, dc_m, c_m}, 4'hF, `ASX_RESP_OKAY);
      exec(ops[i % 6], lf[7:0]);
    end
    for (int i = 5; i < 8; i++) begin
      lf = nx(lf);
      acc_m = lf[7:0];
      dir_m[i - 5] = lf[7:0];
      wr(`ASX_OFF_ACC, {24'h0, acc_m}, 4'hF, `ASX_RESP_OKAY);
      wr(`ASX_OFF_INSTR, {20'h0, `ASX_OP_DIR_LOAD, 8'(i)}, 4'hF, `ASX_RESP_OKAY);
      chk({10'h0, port_c_direction, port_b_direction, port_a_direction},
          {10'h0, dir_m[2], dir_m[1], dir_m[0]});
      rd(`ASX_OFF_STATUS, st_exp());
    end
    wr(`ASX_OFF_INSTR, {20'h0, `ASX_OP_DIR_LOAD, 8'h04}, 4'hF, `ASX_RESP_SLVERR);
    wr(`ASX_OFF_INSTR, 32'h00000900, 4'hF, `ASX_RESP_SLVERR);
    wr(`ASX_OFF_INSTR, {20'h0, `ASX_OP_LIT_XOR, 8'h5A}, 4'h1, `ASX_RESP_OKAY);
    wr(12'h100, 32'h0, 4'hF, `ASX_RESP_SLVERR);
    rd(12'h100, {`ASX_RESP_SLVERR, 32'h0});
    rd(`ASX_OFF_ACC, {26'h0, acc_m});
    wr(`ASX_OFF_INSTR, {20'h0, `ASX_OP_SLEEP, 8'h00}, 4'hF, `ASX_RESP_OKAY);
    pd_m = 1'h0;
    sl_m = 1'h1;
    chk({33'h0, osc_enable}, 34'h0);
    rd(`ASX_OFF_WDT, 34'h0);
    rd(`ASX_OFF_STATUS, st_exp());
    wr(`ASX_OFF_INSTR, {20'h0, `ASX_OP_LIT_XOR, 8'h5A}, 4'hF, `ASX_RESP_SLVERR);
    wake_req <= 1'h1;
    @(posedge sys_clk);
    wake_req <= 1'h0;
    @(posedge sys_clk);
    sl_m = 1'h0;
    chk({33'h0, osc_enable}, 34'h1);
    rd(`ASX_OFF_STATUS, st_exp());
    // second sleep ends by watchdog overflow; its timing shows the watchdog count was cleared
    wr(`ASX_OFF_INSTR, {20'h0, `ASX_OP_SLEEP, 8'h00}, 4'hF, `ASX_RESP_OKAY);
    n = 0;
    while (wdt_timeout !== 1'h1 && n < 300 * PS) begin
      @(posedge sys_clk);
      n++;
    end
    chk({33'h0, n >= 255 * PS - 4 && n <= 256 * PS + 4}, 34'h1);
    @(posedge sys_clk);
    chk({33'h0, osc_enable}, 34'h1);
    to_m = 1'h0;
    rd(`ASX_OFF_STATUS, st_exp());
    end_of_test();
  end
endmodule : alu_subtract_xor_swap_ops_tb_top
`default_nettype wire
